// ==== logic/bst_tap.sv ====
// Test access port controller, instruction decoder and data chains
`timescale 1ns/1ps
`default_nettype none
module bst_tap
    import bst_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_n_out,
    input wire logic [bst_pkg::BSR_W-1:0] pin_in_in,
    output logic [bst_pkg::BSR_W-1:0] pin_out_out,
    output logic test_override_out,
    output logic host_if_off_out,
    output logic [bst_pkg::ADDR_W-1:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [bst_pkg::DATA_W-1:0] reg_wdata_out,
    input wire logic [bst_pkg::DATA_W-1:0] reg_rdata_in
);
    import bst_pkg::*;

    logic tck_rise, tck_fall, tms_s, tdi_s;
    bst_state_t state_ff, nxt_state;
    logic [IR_W-1:0] ir_ff, nxt_ir, irs_ff, nxt_irs;
    logic [ID_W-1:0] dr_ff, nxt_dr;
    logic [BSR_W-1:0] upd_ff, nxt_upd;
    logic ifsw_ff, nxt_ifsw;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic wr_ff, nxt_wr;
    logic [DATA_W-1:0] wdata_ff, nxt_wdata;
    logic tdo_ff, nxt_tdo, oen_ff, nxt_oen;
    logic [BSR_W-1:0] pin_meta_ff, nxt_pin_meta, pin_sync_ff, nxt_pin_sync;
    logic [2:0] ones_ff, nxt_ones;

    bst_edge_sync u_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .tck_in(tck_in),
        .tms_in(tms_in),
        .tdi_in(tdi_in),
        .tck_rise_out(tck_rise),
        .tck_fall_out(tck_fall),
        .tms_out(tms_s),
        .tdi_out(tdi_s)
    );

    // Length of the chain the instruction selects
    function automatic int chain_len(input logic [IR_W-1:0] ins);
        case (ins)
            IR_SAMPLE, IR_EXTEST: chain_len = BSR_W;
            IR_IDCODE, IR_USER: chain_len = ID_W;
            IR_IFSW, IR_BYPASS, IR_CLAMP, IR_HIGHZ: chain_len = 1;
            IR_REGRD, IR_REGWR: chain_len = WR_W;
            default: chain_len = 1;
        endcase
    endfunction

    always_comb begin
        nxt_state = state_ff;
        if (tck_rise) begin
            case (state_ff)
                ST_RESET: nxt_state = tms_s ? ST_RESET : ST_IDLE;
                ST_IDLE: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: nxt_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: nxt_state = tms_s ? ST_UP_DR : ST_PA_DR;
                ST_PA_DR: nxt_state = tms_s ? ST_EX2_DR : ST_PA_DR;
                ST_EX2_DR: nxt_state = tms_s ? ST_UP_DR : ST_SH_DR;
                ST_UP_DR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: nxt_state = tms_s ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: nxt_state = tms_s ? ST_UP_IR : ST_PA_IR;
                ST_PA_IR: nxt_state = tms_s ? ST_EX2_IR : ST_PA_IR;
                ST_EX2_IR: nxt_state = tms_s ? ST_UP_IR : ST_SH_IR;
                ST_UP_IR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
                default: nxt_state = ST_RESET;
            endcase
        end
    end

    always_comb begin
        int len;
        len = chain_len(ir_ff);
        nxt_ir = ir_ff;
        nxt_irs = irs_ff;
        nxt_dr = dr_ff;
        nxt_upd = upd_ff;
        nxt_ifsw = ifsw_ff;
        nxt_addr = addr_ff;
        nxt_wr = 1'b0;
        nxt_wdata = wdata_ff;
        if (tck_rise) begin
            case (state_ff)
                ST_RESET: begin
                    nxt_ir = IR_IDCODE;
                    nxt_ifsw = 1'b0;
                end
                ST_CAP_IR: nxt_irs = IR_CAPT;
                ST_SH_IR: nxt_irs = {tdi_s, irs_ff[IR_W-1:1]};
                ST_UP_IR: nxt_ir = irs_ff;
                ST_CAP_DR: begin
                    nxt_dr = '0;
                    case (ir_ff)
                        IR_SAMPLE, IR_EXTEST: nxt_dr[BSR_W-1:0] = pin_sync_ff;
                        IR_IDCODE: nxt_dr = ID_VALUE;
                        IR_USER: nxt_dr = USER_VALUE;
                        // Read data rides above the current address
                        IR_REGRD: nxt_dr[WR_W-1:0] = {reg_rdata_in, addr_ff};
                        IR_REGWR: begin
                            // Address in low bits, data above
                            if (ifsw_ff) begin
                                nxt_wr = 1'b1;
                                nxt_wdata = dr_ff[WR_W-1:ADDR_W];
                                nxt_addr = dr_ff[ADDR_W-1:0];
                            end
                        end
                        default: nxt_dr = '0;
                    endcase
                end
                ST_SH_DR: begin
                    nxt_dr = dr_ff >> 1;
                    nxt_dr[len-1] = tdi_s;
                end
                ST_UP_DR: begin
                    case (ir_ff)
                        IR_SAMPLE, IR_EXTEST: nxt_upd = dr_ff[BSR_W-1:0];
                        IR_IFSW: nxt_ifsw = dr_ff[0];
                        IR_REGRD: nxt_addr = dr_ff[ADDR_W-1:0];
                        default: nxt_upd = upd_ff;
                    endcase
                end
                default: nxt_ir = ir_ff;
            endcase
        end
    end

    always_comb begin
        nxt_tdo = tdo_ff;
        nxt_oen = oen_ff;
        if (tck_fall) begin
            nxt_oen = !(state_ff == ST_SH_DR || state_ff == ST_SH_IR);
            if (state_ff == ST_SH_IR) begin
                nxt_tdo = irs_ff[0];
            end else if (state_ff == ST_SH_DR) begin
                nxt_tdo = (ir_ff == IR_REGWR) ? 1'b0 : dr_ff[0];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_RESET;
            ir_ff <= IR_IDCODE;
            irs_ff <= IR_CAPT;
            dr_ff <= '0;
            upd_ff <= '0;
            ifsw_ff <= 1'b0;
            addr_ff <= '0;
            wr_ff <= 1'b0;
            wdata_ff <= '0;
            tdo_ff <= 1'b0;
            oen_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            ir_ff <= nxt_ir;
            irs_ff <= nxt_irs;
            dr_ff <= nxt_dr;
            upd_ff <= nxt_upd;
            ifsw_ff <= nxt_ifsw;
            addr_ff <= nxt_addr;
            wr_ff <= nxt_wr;
            wdata_ff <= nxt_wdata;
            tdo_ff <= nxt_tdo;
            oen_ff <= nxt_oen;
        end
    end

    // Pins follow the update latch under extest, clamp or highz
    assign test_override_out = (ir_ff == IR_EXTEST) || (ir_ff == IR_CLAMP)
        || (ir_ff == IR_HIGHZ);
    assign pin_out_out = upd_ff;
    assign host_if_off_out = ifsw_ff;
    assign reg_addr_out = addr_ff;
    assign reg_wr_out = wr_ff;
    assign reg_wdata_out = wdata_ff;
    assign tdo_out = tdo_ff;
    assign tdo_oe_n_out = oen_ff;

    // Boundary pins are asynchronous; mode-high run counter for the reset check
    always_comb begin
        nxt_pin_meta = pin_in_in;
        nxt_pin_sync = pin_meta_ff;
        nxt_ones = ones_ff;
        if (tck_rise) begin
            if (!tms_s) begin
                nxt_ones = 3'h0;
            end else if (ones_ff != 3'(TRST_ONES)) begin
                nxt_ones = ones_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            ones_ff <= 3'h0;
        end else begin
            pin_meta_ff <= nxt_pin_meta;
            pin_sync_ff <= nxt_pin_sync;
            ones_ff <= nxt_ones;
        end
    end

    chk_five_ones_reset: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ones_ff == 3'(TRST_ONES) |-> state_ff == ST_RESET) else $error("five ones missed reset");
    chk_reset_loads_id: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        state_ff == ST_RESET && tck_rise |=> ir_ff == IR_IDCODE) else $error("ir not idcode");
    chk_static_clock_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !tck_rise |=> $stable(state_ff) && $stable(ir_ff) && $stable(dr_ff))
        else $error("state moved without clock");
    chk_tdo_on_fall: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !$past(tck_fall) |-> $stable(tdo_out) && $stable(tdo_oe_n_out))
        else $error("tdo moved off falling edge");
    chk_tdo_idle_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        tck_fall && state_ff == ST_IDLE |=> tdo_oe_n_out) else $error("tdo driven idle");
    chk_ifsw_update: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        tck_rise && state_ff == ST_UP_DR && ir_ff == IR_IFSW |=> host_if_off_out == $past(dr_ff[0]))
        else $error("interface switch not applied");
    chk_write_pulse: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        reg_wr_out |-> $past(state_ff) == ST_CAP_DR && ir_ff == IR_REGWR)
        else $error("stray register write");
    chk_read_capture: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        tck_rise && state_ff == ST_CAP_DR && ir_ff == IR_REGRD |=> dr_ff[ADDR_W-1:0] == reg_addr_out)
        else $error("read address not captured");
    chk_ir_shift: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        tck_rise && state_ff == ST_SH_IR |=> irs_ff[IR_W-1] == $past(tdi_s))
        else $error("ir shift lost data in");
endmodule
`default_nettype wire

// ==== logic/bst_pkg.sv ====
// Constants and types of the boundary scan test port
package bst_pkg;
    localparam int IR_W = 4;
    localparam int BSR_W = 24;
    localparam int ID_W = 32;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int WR_W = ADDR_W + DATA_W;
    localparam int TRST_ONES = 5;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] IR_USER = 4'h3;
    localparam logic [IR_W-1:0] IR_CLAMP = 4'h4;
    localparam logic [IR_W-1:0] IR_HIGHZ = 4'h5;
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h7;
    localparam logic [IR_W-1:0] IR_IFSW = 4'h8;
    localparam logic [IR_W-1:0] IR_REGRD = 4'h9;
    localparam logic [IR_W-1:0] IR_REGWR = 4'ha;
    localparam logic [IR_W-1:0] IR_CAPT = 4'h1;
    // Identity values are arbitrary
    localparam logic [ID_W-1:0] ID_VALUE = 32'h1234_5679;
    localparam logic [ID_W-1:0] USER_VALUE = 32'h0000_0000;
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
        ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
        ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf
    } bst_state_t;
endpackage

// ==== logic/bst_edge_sync.sv ====
// Two-flop synchroniser with rise and fall detection for the test pins
`timescale 1ns/1ps
`default_nettype none
module bst_edge_sync (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tck_rise_out,
    output logic tck_fall_out,
    output logic tms_out,
    output logic tdi_out
);
    logic [2:0] meta_ff, nxt_meta;
    logic [2:0] sync_ff, nxt_sync;
    logic tck_old_ff, nxt_tck_old;

    always_comb begin
        nxt_meta = {tck_in, tms_in, tdi_in};
        nxt_sync = meta_ff;
        nxt_tck_old = sync_ff[2];
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // Pins idle high through their pull-ups
            meta_ff <= '1;
            sync_ff <= '1;
            tck_old_ff <= 1'b1;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            tck_old_ff <= nxt_tck_old;
        end
    end

    assign tck_rise_out = sync_ff[2] & ~tck_old_ff;
    assign tck_fall_out = ~sync_ff[2] & tck_old_ff;
    assign tms_out = sync_ff[1];
    assign tdi_out = sync_ff[0];
endmodule
`default_nettype wire

// ==== tb/bst_ctrl_model.sv ====
// External test controller model driving the four-wire test link
`timescale 1ns/1ps
`default_nettype none
module bst_ctrl_model (
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end
    // Clock stands still between calls; mode and data change while it is low
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out <= tms;
        tdi_out <= tdi;
        #62.5;
        tdo = tdo_in;
        tck_out <= 1'b1;
        #62.5;
        tck_out <= 1'b0;
    endtask
    task automatic go_reset();
        logic d;
        for (int i = 0; i < 5; i++) begin
            step(1'b1, 1'b1, d);
        end
        step(1'b0, 1'b1, d);
    endtask
    task automatic load_ir(input logic [3:0] code, output logic [3:0] cap);
        logic d;
        step(1'b1, 1'b1, d);
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
        step(1'b0, 1'b1, d);
        for (int i = 0; i < 4; i++) begin
            step(i == 3, code[i], cap[i]);
        end
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
    endtask
    // Data scan of n bits, LSB first, ending with update and idle
    task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic d;
        dout = '0;
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
        step(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
    endtask
endmodule
`default_nettype wire

// ==== tb/boundary_scan_test_port_tb_top.sv ====
// Testbench of the boundary scan test port
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_test_port_tb_top;
    import bst_pkg::*;
    logic clock_in, rst_n_in;
    wire logic tck, tms, tdi;
    logic tdo, tdo_oe_n, override, if_off, reg_wr;
    logic [BSR_W-1:0] pin_in, pin_out;
    logic [ADDR_W-1:0] reg_addr, wr_addr;
    logic [DATA_W-1:0] reg_wdata, wr_data, rdata;
    logic [31:0] dout;
    logic [3:0] cap;
    int n_fail, n_compared, n_wr;
    bst_ctrl_model u_ctrl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
    bst_tap u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .pin_in_in(pin_in),
        .pin_out_out(pin_out), .test_override_out(override), .host_if_off_out(if_off),
        .reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata),
        .reg_rdata_in(rdata));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        if (reg_wr === 1'b1) begin
            n_wr <= n_wr + 1;
            wr_addr <= reg_addr;
            wr_data <= reg_wdata;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("Counts: %0d compared, %0d failed", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic test_id_default();
        chk("idle oe_n", 32'h1, {31'h0, tdo_oe_n});
        u_ctrl.go_reset();
        u_ctrl.scan_dr(ID_W, 32'h0, dout);
        chk("default id", ID_VALUE, dout);
        #20000;
        u_ctrl.scan_dr(ID_W, 32'hffff_ffff, dout);
        chk("id after stop", ID_VALUE, dout);
        $display("test_id_default done");
    endtask
    task automatic test_codes();
        u_ctrl.load_ir(IR_USER, cap);
        chk("ir capture", {28'h0, IR_CAPT}, {28'h0, cap});
        u_ctrl.scan_dr(ID_W, 32'hffff_ffff, dout);
        chk("user code", USER_VALUE, dout);
        u_ctrl.load_ir(IR_BYPASS, cap);
        u_ctrl.scan_dr(2, 32'h3, dout);
        chk("bypass", 32'h2, dout);
        @(posedge clock_in) pin_in <= 24'ha5_c396;
        u_ctrl.load_ir(IR_SAMPLE, cap);
        u_ctrl.scan_dr(BSR_W, 32'h003c_5a69, dout);
        chk("sample", 32'h00a5_c396, dout);
        u_ctrl.load_ir(IR_EXTEST, cap);
        chk("extest pins", 32'h003c_5a69, {8'h0, pin_out});
        chk("extest override", 32'h1, {31'h0, override});
        u_ctrl.load_ir(IR_CLAMP, cap);
        chk("clamp override", 32'h1, {31'h0, override});
        u_ctrl.load_ir(IR_HIGHZ, cap);
        chk("highz override", 32'h1, {31'h0, override});
        u_ctrl.load_ir(IR_SAMPLE, cap);
        chk("sample override", 32'h0, {31'h0, override});
        $display("test_codes done");
    endtask
    task automatic test_mid_reset();
        logic d;
        u_ctrl.load_ir(IR_USER, cap);
        u_ctrl.step(1'b1, 1'b1, d);
        u_ctrl.step(1'b0, 1'b1, d);
        u_ctrl.step(1'b0, 1'b1, d);
        u_ctrl.go_reset();
        u_ctrl.scan_dr(ID_W, 32'h0, dout);
        chk("id after mid reset", ID_VALUE, dout);
        $display("test_mid_reset done");
    endtask
    task automatic test_reg_access();
        u_ctrl.load_ir(IR_REGWR, cap);
        u_ctrl.scan_dr(WR_W, 32'h0000_61ad, dout);
        u_ctrl.scan_dr(WR_W, 32'h0000_61ad, dout);
        chk("refused writes", 32'h0, n_wr);
        u_ctrl.load_ir(IR_IFSW, cap);
        u_ctrl.scan_dr(1, 32'h1, dout);
        chk("interface off", 32'h1, {31'h0, if_off});
        u_ctrl.load_ir(IR_REGRD, cap);
        u_ctrl.scan_dr(WR_W, 32'h5a, dout);
        chk("read before access", 32'h0000_1e00, dout);
        chk("read address set", 32'h5a, {25'h0, reg_addr});
        u_ctrl.scan_dr(WR_W, 32'h11, dout);
        chk("read captured", 32'h0000_1e5a, dout);
        chk("read address next", 32'h11, {25'h0, reg_addr});
        u_ctrl.load_ir(IR_REGWR, cap);
        u_ctrl.scan_dr(WR_W, 32'h0000_61ad, dout);
        u_ctrl.scan_dr(WR_W, 32'h0000_61ad, dout);
        chk("write issued", 32'h1, {31'h0, n_wr > 0});
        chk("write address", 32'h2d, {25'h0, wr_addr});
        chk("write data", 32'hc3, {24'h0, wr_data});
        $display("test_reg_access done");
    endtask
    initial begin
        n_fail = 0;
        n_compared = 0;
        n_wr = 0;
        rst_n_in = 1'b0;
        pin_in = '0;
        rdata = 8'h3c;
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge clock_in);
        test_id_default();
        test_codes();
        test_mid_reset();
        test_reg_access();
        end_sim();
    end
    initial begin
        #500000;
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
